// File: hdl/strap_pkg.sv
// constants of the strap decode, register map and status pin logic
package strap_pkg;

  // four-level strap encoding, in level order L, R, F, H
  localparam logic [1:0] LVL_L = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] LVL_H = 2'h3;

  // drive codes chosen by the drive strength strap
  localparam logic [2:0] DRV_CODE_H = 3'h0;
  localparam logic [2:0] DRV_CODE_F = 3'h2;
  localparam logic [2:0] DRV_CODE_R = 3'h3;
  localparam logic [2:0] DRV_CODE_L = 3'h5;

  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h1D;

  // register offsets
  localparam logic [7:0] OFS_FIRST_SWING = 8'h30;
  localparam logic [7:0] OFS_FIRST_DEEMPH = 8'h31;
  localparam logic [7:0] OFS_SECOND_SWING = 8'h32;
  localparam logic [7:0] OFS_SECOND_DEEMPH = 8'h33;
  localparam logic [7:0] OFS_STATUS_SEL = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h11;
  localparam logic [7:0] OFS_INT_STATUS = 8'h12;

  // field positions
  localparam int SWING_OVR_BIT = 5;
  localparam int DEEMPH_OVR_BIT = 6;
  localparam int NUM_INT_SRC = 5;

  // reset values
  localparam logic [7:0] DRV_REG_RST = 8'h00;
  localparam logic [1:0] STATUS_SEL_RST = 2'h0;
  localparam logic [4:0] INT_MASK_RST = 5'h00;

  // interrupt source bit positions
  localparam int SRC_LOSS_SET = 0;
  localparam int SRC_LOSS_CLR = 1;
  localparam int SRC_EYE_LOW = 2;
  localparam int SRC_LOCK_GAIN = 3;
  localparam int SRC_LOCK_LOSE = 4;

  typedef enum logic [2:0] {
    PIN_LOCK = 3'b001,
    PIN_CARRIER = 3'b010,
    PIN_INT = 3'b100
  } pin_view_t;

  localparam logic [1:0] SEL_LOCK = 2'h0;
  localparam logic [1:0] SEL_CARRIER = 2'h1;
  localparam logic [1:0] SEL_INT = 2'h2;

endpackage : strap_pkg

// File: hdl/strap_if.sv
// strap levels in and latched decode out, between top and latch
`timescale 1ns/1ps
interface strap_if;
  logic [1:0] drive_strength_strap;
  logic [1:0] mode_strap;
  logic [1:0] addr_strap_a;
  logic [1:0] addr_strap_b;
  logic [1:0] drive_lvl;
  logic [1:0] mode_lvl;
  logic [6:0] slave_addr;
  logic latched;

  modport latch (
    input drive_strength_strap,
    input mode_strap,
    input addr_strap_a,
    input addr_strap_b,
    output drive_lvl,
    output mode_lvl,
    output slave_addr,
    output latched
  );

  modport user (
    output drive_strength_strap,
    output mode_strap,
    output addr_strap_a,
    output addr_strap_b,
    input drive_lvl,
    input mode_lvl,
    input slave_addr,
    input latched
  );
endinterface : strap_if

// File: hdl/strap_latch.sv
// one-time capture of the four-level straps after reset release
`timescale 1ns/1ps
module strap_latch (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  strap_if.latch st
);

  logic latched_reg;
  logic [1:0] drive_lvl_reg;
  logic [1:0] mode_lvl_reg;
  logic [6:0] slave_addr_reg;

  // capture once, then hold
  // reset takes constants; pins are sampled at the first enabled edge after release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      latched_reg <= 1'b0;
      drive_lvl_reg <= strap_pkg::LVL_H;
      mode_lvl_reg <= strap_pkg::LVL_L;
      slave_addr_reg <= strap_pkg::SLAVE_ADDR_BASE;
    end else if (clk_en && !latched_reg) begin
      latched_reg <= 1'b1;
      drive_lvl_reg <= st.drive_strength_strap;
      mode_lvl_reg <= st.mode_strap;
      slave_addr_reg <= strap_pkg::SLAVE_ADDR_BASE
        + {3'h0, st.addr_strap_a, 2'h0} + {5'h00, st.addr_strap_b};
    end
  end

  assign st.latched = latched_reg;
  assign st.drive_lvl = drive_lvl_reg;
  assign st.mode_lvl = mode_lvl_reg;
  assign st.slave_addr = slave_addr_reg;

endmodule : strap_latch

// File: hdl/strap_status_control.sv
// strap decode, driver overrides and status pin logic of the reclocker
`timescale 1ns/1ps
module strap_status_control #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [1:0] drive_strength_strap,
  input wire logic [1:0] mode_strap,
  input wire logic [1:0] addr_strap_a,
  input wire logic [1:0] addr_strap_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic cdr_locked,
  input wire logic carrier_detected,
  input wire logic adapt_done,
  input wire logic signal_loss,
  input wire logic eye_below_threshold,
  output logic [2:0] first_driver_swing,
  output logic [2:0] first_driver_deemph,
  output logic [2:0] second_driver_swing,
  output logic [2:0] second_driver_deemph,
  output logic smbus_mode,
  output logic spi_mode,
  output logic power_save,
  output logic [6:0] slave_addr,
  output logic status_pin_out,
  output logic status_pin_oe
);

  // ****************************************
  // parameter checks
  // ****************************************
  generate
    if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_width
      $error("register port must be 8 bits of address and data");
    end
  endgenerate

  // ****************************************
  // strap capture
  // ****************************************
  strap_if st ();
  assign st.drive_strength_strap = drive_strength_strap;
  assign st.mode_strap = mode_strap;
  assign st.addr_strap_a = addr_strap_a;
  assign st.addr_strap_b = addr_strap_b;

  strap_latch u_latch (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .st(st)
  );

  // four-level strap to drive code
  function automatic logic [2:0] strap_code(input logic [1:0] lvl);
    case (lvl)
      strap_pkg::LVL_H: strap_code = strap_pkg::DRV_CODE_H;
      strap_pkg::LVL_F: strap_code = strap_pkg::DRV_CODE_F;
      strap_pkg::LVL_R: strap_code = strap_pkg::DRV_CODE_R;
      default: strap_code = strap_pkg::DRV_CODE_L;
    endcase
  endfunction : strap_code

  // override bit chooses register field over strap
  function automatic logic [2:0] pick_code(input logic ovr, input logic [2:0] fld,
                                           input logic [2:0] strap);
    pick_code = ovr ? fld : strap;
  endfunction : pick_code

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] swing_reg [2];
  logic [7:0] deemph_reg [2];
  logic [1:0] status_sel_reg;
  logic [4:0] int_mask_reg;
  logic [4:0] int_flag_reg;
  logic [4:0] int_flag_next;
  logic [4:0] int_event;
  logic [4:0] int_clear;
  logic [DATA_W-1:0] rdata_reg;

  // only the override bit and the 3-bit code are stored; other bits read zero
  localparam logic [7:0] SWING_KEEP = 8'h27;
  localparam logic [7:0] DEEMPH_KEEP = 8'h47;

  // each driver has its own register pair
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      swing_reg[0] <= strap_pkg::DRV_REG_RST;
      swing_reg[1] <= strap_pkg::DRV_REG_RST;
      deemph_reg[0] <= strap_pkg::DRV_REG_RST;
      deemph_reg[1] <= strap_pkg::DRV_REG_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == strap_pkg::OFS_FIRST_SWING) begin
        swing_reg[0] <= reg_wdata & SWING_KEEP;
      end else if (reg_addr == strap_pkg::OFS_SECOND_SWING) begin
        swing_reg[1] <= reg_wdata & SWING_KEEP;
      end else if (reg_addr == strap_pkg::OFS_FIRST_DEEMPH) begin
        deemph_reg[0] <= reg_wdata & DEEMPH_KEEP;
      end else if (reg_addr == strap_pkg::OFS_SECOND_DEEMPH) begin
        deemph_reg[1] <= reg_wdata & DEEMPH_KEEP;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_sel_reg <= strap_pkg::STATUS_SEL_RST;
      int_mask_reg <= strap_pkg::INT_MASK_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == strap_pkg::OFS_STATUS_SEL) begin
        status_sel_reg <= reg_wdata[1:0];
      end else if (reg_addr == strap_pkg::OFS_INT_MASK) begin
        int_mask_reg <= reg_wdata[4:0];
      end
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == strap_pkg::OFS_FIRST_SWING) begin
        rdata_reg <= swing_reg[0];
      end else if (reg_addr == strap_pkg::OFS_SECOND_SWING) begin
        rdata_reg <= swing_reg[1];
      end else if (reg_addr == strap_pkg::OFS_FIRST_DEEMPH) begin
        rdata_reg <= deemph_reg[0];
      end else if (reg_addr == strap_pkg::OFS_SECOND_DEEMPH) begin
        rdata_reg <= deemph_reg[1];
      end else if (reg_addr == strap_pkg::OFS_STATUS_SEL) begin
        rdata_reg <= {6'h00, status_sel_reg};
      end else if (reg_addr == strap_pkg::OFS_INT_MASK) begin
        rdata_reg <= {3'h0, int_mask_reg};
      end else if (reg_addr == strap_pkg::OFS_INT_STATUS) begin
        rdata_reg <= {3'h0, int_flag_reg};
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  // ****************************************
  // interrupt sources
  // ****************************************
  logic loss_d_reg;
  logic lock_d_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loss_d_reg <= 1'b0;
      lock_d_reg <= 1'b0;
    end else if (clk_en) begin
      loss_d_reg <= signal_loss;
      lock_d_reg <= cdr_locked;
    end
  end

  always_comb begin
    int_event = '0;
    // loss of signal begins and ends
    int_event[strap_pkg::SRC_LOSS_SET] = signal_loss && !loss_d_reg;
    int_event[strap_pkg::SRC_LOSS_CLR] = !signal_loss && loss_d_reg;
    // low eye counts only while locked
    int_event[strap_pkg::SRC_EYE_LOW] = eye_below_threshold && cdr_locked;
    int_event[strap_pkg::SRC_LOCK_GAIN] = cdr_locked && !lock_d_reg;
    int_event[strap_pkg::SRC_LOCK_LOSE] = !cdr_locked && lock_d_reg;
  end

  // clear on status read; a new event in that cycle wins
  always_comb begin
    int_clear = '0;
    if (reg_rd && reg_addr == strap_pkg::OFS_INT_STATUS) begin
      int_clear = int_flag_reg;
    end
    int_flag_next = (int_flag_reg & ~int_clear) | int_event;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_flag_reg <= '0;
    end else if (clk_en) begin
      int_flag_reg <= int_flag_next;
    end
  end

  // ****************************************
  // driver codes
  // ****************************************
  logic [2:0] swing_out_reg [2];
  logic [2:0] deemph_out_reg [2];

  generate
    for (genvar i = 0; i < 2; i++) begin : g_drv
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          swing_out_reg[i] <= strap_pkg::DRV_CODE_H;
          deemph_out_reg[i] <= strap_pkg::DRV_CODE_H;
        end else if (clk_en) begin
          // strap code shared by both drivers
          swing_out_reg[i] <= pick_code(swing_reg[i][strap_pkg::SWING_OVR_BIT],
                                        swing_reg[i][2:0], strap_code(st.drive_lvl));
          deemph_out_reg[i] <= pick_code(deemph_reg[i][strap_pkg::DEEMPH_OVR_BIT],
                                         deemph_reg[i][2:0], strap_code(st.drive_lvl));
        end
      end
    end
  endgenerate

  // ****************************************
  // interface mode and address
  // ****************************************
  logic smbus_reg;
  logic spi_reg;
  logic psave_reg;
  logic [6:0] addr_reg;

  // level R is factory test; it selects neither bus here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      smbus_reg <= 1'b0;
      spi_reg <= 1'b0;
      psave_reg <= 1'b0;
      addr_reg <= strap_pkg::SLAVE_ADDR_BASE;
    end else if (clk_en && st.latched) begin
      smbus_reg <= (st.mode_lvl == strap_pkg::LVL_L);
      // level H keeps only the four-wire port
      spi_reg <= (st.mode_lvl == strap_pkg::LVL_F) || (st.mode_lvl == strap_pkg::LVL_H);
      psave_reg <= (st.mode_lvl == strap_pkg::LVL_H);
      // address straps only meaningful in two-wire mode
      addr_reg <= st.slave_addr;
    end
  end

  // ****************************************
  // status pin
  // ****************************************
  strap_pkg::pin_view_t view;
  logic pin_low;
  logic pin_oe_reg;

  always_comb begin
    if (status_sel_reg == strap_pkg::SEL_CARRIER) begin
      view = strap_pkg::PIN_CARRIER;
    end else if (status_sel_reg == strap_pkg::SEL_INT) begin
      view = strap_pkg::PIN_INT;
    end else begin
      view = strap_pkg::PIN_LOCK;
    end
  end

  always_comb begin
    case (view)
      // low only after detect and adaptation
      strap_pkg::PIN_CARRIER: pin_low = carrier_detected && adapt_done;
      // any flag with its mask set
      strap_pkg::PIN_INT: pin_low = |(int_flag_reg & int_mask_reg);
      default: pin_low = cdr_locked;
    endcase
  end

  // open drain: output stays low, enable high while pulling down
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_oe_reg <= 1'b0;
    end else if (clk_en) begin
      pin_oe_reg <= pin_low;
    end
  end

  assign first_driver_swing = swing_out_reg[0];
  assign second_driver_swing = swing_out_reg[1];
  assign first_driver_deemph = deemph_out_reg[0];
  assign second_driver_deemph = deemph_out_reg[1];
  assign smbus_mode = smbus_reg;
  assign spi_mode = spi_reg;
  assign power_save = psave_reg;
  assign slave_addr = addr_reg;
  assign reg_rdata = rdata_reg;
  assign status_pin_out = 1'b0;
  assign status_pin_oe = pin_oe_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_first_swing_src: assert property (clk_en |=> first_driver_swing ==
    ($past(swing_reg[0][5]) ? $past(swing_reg[0][2:0]) : strap_code($past(st.drive_lvl))))
    else $error("first driver swing source wrong");
  a_second_deemph_src: assert property (clk_en |=> second_driver_deemph ==
    ($past(deemph_reg[1][6]) ? $past(deemph_reg[1][2:0]) : strap_code($past(st.drive_lvl))))
    else $error("second driver deemphasis source wrong");
  a_strap_both_same: assert property ((!swing_reg[0][5] && !swing_reg[1][5])
    ##1 (!swing_reg[0][5] && !swing_reg[1][5] && clk_en) |=>
    first_driver_swing == second_driver_swing)
    else $error("strap swing differs between drivers");
  a_int_pin_low: assert property (clk_en && view == strap_pkg::PIN_INT
    && |(int_flag_reg & int_mask_reg) |=> status_pin_oe)
    else $error("interrupt view not pulling low");
  a_lock_pin_view: assert property (clk_en && view == strap_pkg::PIN_LOCK
    |=> status_pin_oe == $past(cdr_locked))
    else $error("lock view does not follow lock");
  a_carrier_view: assert property (clk_en && view == strap_pkg::PIN_CARRIER
    && !adapt_done |=> !status_pin_oe)
    else $error("carrier view low before adaptation");
  a_flag_sticky: assert property (clk_en && int_flag_reg[0]
    && !(reg_rd && reg_addr == strap_pkg::OFS_INT_STATUS) |=> int_flag_reg[0])
    else $error("interrupt flag dropped without read");
  a_read_clears: assert property (clk_en && reg_rd && reg_addr == strap_pkg::OFS_INT_STATUS
    && int_event == 5'h00 |=> int_flag_reg == 5'h00 && reg_rdata[4:0] == $past(int_flag_reg))
    else $error("status read does not clear flags");
  a_set_wins: assert property (clk_en && int_event[4] |=> int_flag_reg[4])
    else $error("lock loss event lost");
  a_eye_needs_lock: assert property (clk_en && !cdr_locked && !int_flag_reg[2]
    && !(eye_below_threshold && cdr_locked) |=> !int_flag_reg[2])
    else $error("eye flag set without lock");
  a_mode_decode: assert property (st.latched && clk_en |=>
    smbus_mode == (st.mode_lvl == strap_pkg::LVL_L) && power_save == (st.mode_lvl == 2'h3))
    else $error("interface mode decode wrong");
  a_latch_once: assert property (st.latched |=> $stable(st.mode_lvl) && st.latched)
    else $error("strap changed after capture");

  c_override: cover property (clk_en && swing_reg[0][5] ##1 first_driver_swing == 3'h7);
  c_int_clear: cover property (status_pin_oe && view == strap_pkg::PIN_INT ##[1:20] !status_pin_oe);
  c_smbus: cover property (smbus_mode && slave_addr == 7'h23);

endmodule : strap_status_control

// File: test/host_model.sv
// host controller model driving the register strobe port
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // ****************
  // bus cycles
  // ****************
  // idle lines show the inverse of the last value, so a stale match cannot pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : read_reg
endmodule : host_model

// File: test/tb_top.sv
// self-checking bench for strap decode, driver overrides and status pin
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rstn, clk_en;
  logic [1:0] drive_strength_strap, mode_strap, addr_strap_a, addr_strap_b;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic cdr_locked, carrier_detected, adapt_done, signal_loss, eye_below_threshold;
  logic [2:0] first_driver_swing, first_driver_deemph;
  logic [2:0] second_driver_swing, second_driver_deemph;
  logic smbus_mode, spi_mode, power_save, status_pin_out, status_pin_oe;
  logic [6:0] slave_addr;
  logic [1:0] lv, md;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int order[5] = '{0, 1, 3, 2, 4};

  strap_status_control strap_status_control_inst (
    .clk_sys, .rstn, .clk_en, .drive_strength_strap, .mode_strap,
    .addr_strap_a, .addr_strap_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .cdr_locked, .carrier_detected, .adapt_done, .signal_loss,
    .eye_below_threshold, .first_driver_swing, .first_driver_deemph,
    .second_driver_swing, .second_driver_deemph, .smbus_mode, .spi_mode,
    .power_save, .slave_addr, .status_pin_out, .status_pin_oe
  );

  host_model host_model_inst (
    .clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ****************
  // helpers
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_n

  function automatic logic [2:0] drv_code(input logic [1:0] l);
    case (l)
      strap_pkg::LVL_L: return strap_pkg::DRV_CODE_L;
      strap_pkg::LVL_R: return strap_pkg::DRV_CODE_R;
      strap_pkg::LVL_F: return strap_pkg::DRV_CODE_F;
      default: return strap_pkg::DRV_CODE_H;
    endcase
  endfunction : drv_code

  task automatic power_up(input logic [1:0] l);
    @(negedge clk_sys);
    rstn = 1'b0;
    drive_strength_strap = l;
    // interface strap never at level R
    mode_strap = (l == strap_pkg::LVL_R) ? strap_pkg::LVL_L : l;
    addr_strap_a = l;
    addr_strap_b = ~l;
    wait_n(8);
    rstn = 1'b1;
    wait_n(4);
  endtask : power_up

  task automatic fire(input int k);
    case (k)
      0: signal_loss = 1'b1;
      1: signal_loss = 1'b0;
      2: eye_below_threshold = 1'b1;
      3: cdr_locked = 1'b1;
      default: cdr_locked = 1'b0;
    endcase
    wait_n(1);
    eye_below_threshold = 1'b0;
  endtask : fire

  // ****************
  // main sequence
  // ****************
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    {drive_strength_strap, mode_strap, addr_strap_a, addr_strap_b} = 8'h00;
    {cdr_locked, carrier_detected, adapt_done, signal_loss, eye_below_threshold} = 5'h00;
    for (int i = 0; i < 4; i++) begin
      lv = 2'(i);
      md = (lv == strap_pkg::LVL_R) ? strap_pkg::LVL_L : lv;
      power_up(lv);
      // only the drive strap and address strap a move after power-up
      drive_strength_strap = ~lv;
      addr_strap_a = ~lv;
      wait_n(3);
      check(first_driver_swing, drv_code(lv), "swing a");
      check(first_driver_deemph, drv_code(lv), "deemph a");
      check(second_driver_swing, drv_code(lv), "swing b");
      check(second_driver_deemph, drv_code(lv), "deemph b");
      check(smbus_mode, md == strap_pkg::LVL_L, "smbus");
      check(spi_mode, md != strap_pkg::LVL_L, "spi");
      check(power_save, md == strap_pkg::LVL_H, "save");
      if (md == strap_pkg::LVL_L) begin
        check(slave_addr, strap_pkg::SLAVE_ADDR_BASE + {3'h0, lv, ~lv}, "addr");
        check({slave_addr, 1'b0}, {strap_pkg::SLAVE_ADDR_BASE + {3'h0, lv, ~lv}, 1'b0}, "wbyte");
      end
    end
    power_up(strap_pkg::LVL_L);
    for (int i = 0; i < 4; i++) begin
      host_model_inst.read_reg(strap_pkg::OFS_FIRST_SWING + 8'(i), rd);
      check(rd, strap_pkg::DRV_REG_RST, "drv reg reset");
    end
    host_model_inst.write_reg(strap_pkg::OFS_FIRST_SWING, 8'hFF);
    host_model_inst.write_reg(strap_pkg::OFS_SECOND_DEEMPH, 8'hFE);
    host_model_inst.write_reg(8'h55, 8'hFF);
    wait_n(3);
    check(first_driver_swing, 8'h07, "ovr swing a");
    check(second_driver_swing, 8'h05, "strap swing b");
    check(second_driver_deemph, 8'h06, "ovr deemph b");
    check(first_driver_deemph, 8'h05, "strap deemph a");
    host_model_inst.read_reg(strap_pkg::OFS_FIRST_SWING, rd);
    check(rd, 8'h27, "swing reg");
    host_model_inst.read_reg(strap_pkg::OFS_SECOND_DEEMPH, rd);
    check(rd, 8'h46, "deemph reg");
    host_model_inst.read_reg(8'h55, rd);
    check(rd, 8'h00, "unmapped");
    // override bit cleared: strap code returns
    host_model_inst.write_reg(strap_pkg::OFS_FIRST_SWING, 8'h07);
    wait_n(3);
    check(first_driver_swing, 8'h05, "ovr off");
    clk_en = 1'b0;
    host_model_inst.write_reg(strap_pkg::OFS_SECOND_SWING, 8'h21);
    clk_en = 1'b1;
    host_model_inst.read_reg(strap_pkg::OFS_SECOND_SWING, rd);
    check(rd, 8'h00, "gated write");
    check(status_pin_out, 8'h00, "pin drive");
    cdr_locked = 1'b1;
    wait_n(3);
    check(status_pin_oe, 8'h01, "lock low");
    cdr_locked = 1'b0;
    wait_n(3);
    check(status_pin_oe, 8'h00, "unlock high");
    host_model_inst.write_reg(strap_pkg::OFS_STATUS_SEL, 8'h01);
    carrier_detected = 1'b1;
    wait_n(3);
    check(status_pin_oe, 8'h00, "no adapt");
    adapt_done = 1'b1;
    wait_n(3);
    check(status_pin_oe, 8'h01, "carrier low");
    host_model_inst.write_reg(strap_pkg::OFS_STATUS_SEL, 8'h02);
    host_model_inst.read_reg(strap_pkg::OFS_INT_STATUS, rd);
    for (int j = 0; j < 5; j++) begin
      host_model_inst.write_reg(strap_pkg::OFS_INT_MASK, 8'(1 << order[j]));
      fire(order[j]);
      wait_n(3);
      check(status_pin_oe, 8'h01, "int low");
      host_model_inst.read_reg(strap_pkg::OFS_INT_STATUS, rd);
      check(rd, 8'(1 << order[j]), "int source");
      wait_n(2);
      check(status_pin_oe, 8'h00, "int cleared");
    end
    // masked source still flags but leaves the pin high
    host_model_inst.write_reg(strap_pkg::OFS_INT_MASK, 8'h00);
    // low eye while unlocked must leave no flag
    fire(2);
    fire(3);
    wait_n(3);
    check(status_pin_oe, 8'h00, "masked");
    host_model_inst.read_reg(strap_pkg::OFS_INT_STATUS, rd);
    check(rd, 8'h08, "masked flag");
    give_verdict();
  end
endmodule : tb_top
